// ==== logic/pbcs_top.sv ====
// Base clock selector and loop control registers
//
// How it works
// - A feedback multiplier of zero is output as one; the register reads back the zero.
// - Range multiplier zero turns the loop off and forces the crystal source.
// - Outside stop, a source change holds the output through three old and three new edges.
// - The selected source is divided by two for a 50% duty output.
// - Selecting the VCO is ignored while the loop power bit is clear.
// - Clearing loop power is ignored while the VCO is selected.
// - Power and select change in one write only from on/crystal (clear power, set select) or off/VCO (set power, clear select); VCO needs two writes from off.
// - In manual mode the irq enable is unwritable, reads zero; reset clears it.
// - Lock toggles set the flag; irq output is flag, enable and automatic mode together, held low in stop.
// - In manual mode the lock-change flag reads zero; reset clears it.
// - A control register read clears the flag unless a lock toggle sets it in that cycle; writes cannot touch it.
// - Reset sets the loop power bit; one is on, zero is off.
// - Reset and stop clear the base clock select bit.
// - Select one drives VCO over two, zero drives crystal over two.
// - The four low control bits read as ones and ignore writes.
// - Automatic bandwidth bit is read/write, one automatic, reset to manual.
// - Lock indicator reads set when locked in automatic mode, else zero.
//
// Design decisions made here: the address map and the plain strobed port.
`include "pbcs_defs.svh"

module pbcs_top
(
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic [`PBCS_ADDR_W-1:0]  addr,
  input  wire logic [7:0]               wdata,
  input  wire logic                     wr,
  input  wire logic                     rd,
  output logic      [7:0]               rdata,
  input  wire logic                     crystal_clock,
  input  wire logic                     vco_clock,
  input  wire logic                     lock_detect_in,
  input  wire logic                     tracking_status_in,
  input  wire logic                     oscillator_enable_in,
  input  wire logic                     stop_in,
  output logic                          base_clock_out,
  output logic                          lock_irq_out,
  output logic                          crystal_enable_out,
  output logic                          loop_enable_out,
  output logic                          tracking_mode_out,
  output logic      [3:0]               feedback_mult_out,
  output logic      [3:0]               range_mult_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [`PBCS_SYNC_N-1:0] pin_in;
  logic [`PBCS_SYNC_N-1:0] pin_lvl;
  logic [`PBCS_SYNC_N-1:0] pin_rise;

  assign pin_in = {tracking_status_in, lock_detect_in, vco_clock, crystal_clock};

  genvar gi;
  generate
    for (gi = 0; gi < `PBCS_SYNC_N; gi = gi + 1)
    begin : g_sync
      pbcs_sync u_sync
      (
        .clk       (clk),
        .rst       (rst),
        .async_in  (pin_in[gi]),
        .level_out (pin_lvl[gi]),
        .rise_out  (pin_rise[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Register state

  logic       ie_q;
  logic       flag_q;
  logic       pwr_q;
  logic       bcs_q;
  logic       auto_q;
  logic       trk_q;
  logic [3:0] mul_q;
  logic [3:0] rng_q;
  logic       lock_prev_q;

  logic wr_ctrl;
  logic wr_bwc;
  logic wr_prog;
  logic rd_ctrl;
  logic rng_zero;
  logic lock_vis;
  logic lock_toggle;

  function automatic logic hit(input logic [`PBCS_ADDR_W-1:0] a,
                               input logic [`PBCS_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  assign wr_ctrl     = wr & hit(addr, `PBCS_OFF_CTRL);
  assign wr_bwc      = wr & hit(addr, `PBCS_OFF_BWC);
  assign wr_prog     = wr & hit(addr, `PBCS_OFF_PROG);
  assign rd_ctrl     = rd & hit(addr, `PBCS_OFF_CTRL);
  assign rng_zero    = (rng_q == `PBCS_NIB_ZERO);
  assign lock_vis    = auto_q & pin_lvl[`PBCS_SYNC_LOCK];
  assign lock_toggle = (lock_vis != lock_prev_q);

  // Loop power: set by reset, clear refused while VCO selected
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pwr_q <= 1'b1;
    else if (wr_ctrl && !(bcs_q && !wdata[`PBCS_CTRL_PWR]))
      pwr_q <= wdata[`PBCS_CTRL_PWR];
  end

  // Base clock select: set only while the loop is already on
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      bcs_q <= 1'b0;
    else if (stop_in || rng_zero)
      bcs_q <= 1'b0;
    else if (wr_ctrl && (pwr_q || !wdata[`PBCS_CTRL_BCS]))
      bcs_q <= wdata[`PBCS_CTRL_BCS];
  end

  // Irq enable writable only in automatic mode
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ie_q <= 1'b0;
    else if (wr_ctrl && auto_q)
      ie_q <= wdata[`PBCS_CTRL_IE];
  end

  // Lock-change flag: set wins over the read clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      flag_q      <= 1'b0;
      lock_prev_q <= 1'b0;
    end
    else
    begin
      lock_prev_q <= lock_vis;
      if (lock_toggle)
        flag_q <= 1'b1;
      else if (rd_ctrl)
        flag_q <= 1'b0;
    end
  end

  // Bandwidth control: automatic bit and manual tracking select
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      auto_q <= 1'b0;
      trk_q  <= 1'b0;
    end
    else if (wr_bwc)
    begin
      auto_q <= wdata[`PBCS_BWC_AUTO];
      if (!auto_q)
        trk_q <= wdata[`PBCS_BWC_TRK];
    end
  end

  // Programming fields locked while the loop is on
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mul_q <= `PBCS_MUL_RESET;
      rng_q <= `PBCS_RNG_RESET;
    end
    else if (wr_prog && !pwr_q)
    begin
      mul_q <= wdata[7:4];
      rng_q <= wdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read port

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata <= 8'h00;
    else if (rd)
    begin
      case (addr)
        `PBCS_OFF_CTRL:
          rdata <= {ie_q & auto_q, flag_q & auto_q, pwr_q, bcs_q,
                    `PBCS_CTRL_LOW_ONES};
        `PBCS_OFF_BWC:
          rdata <= {auto_q, lock_vis,
                    auto_q ? pin_lvl[`PBCS_SYNC_TRK] : trk_q, 5'h00};
        `PBCS_OFF_PROG:
          rdata <= {mul_q, rng_q};
        default:
          rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Loop control outputs

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lock_irq_out       <= 1'b0;
      crystal_enable_out <= 1'b0;
      loop_enable_out    <= 1'b0;
      tracking_mode_out  <= 1'b0;
      feedback_mult_out  <= `PBCS_MUL_ONE;
      range_mult_out     <= `PBCS_RNG_RESET;
    end
    else
    begin
      lock_irq_out       <= flag_q & ie_q & auto_q & ~stop_in;
      crystal_enable_out <= oscillator_enable_in & ~stop_in;
      loop_enable_out    <= oscillator_enable_in & pwr_q & ~rng_zero
                            & ~stop_in;
      tracking_mode_out  <= auto_q ? pin_lvl[`PBCS_SYNC_TRK] : trk_q;
      feedback_mult_out  <= (mul_q == `PBCS_NIB_ZERO) ? `PBCS_MUL_ONE : mul_q;
      range_mult_out     <= rng_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Glitch-free source switch and divide by two

  pbcs_pkg::pbcs_state_t state_q;
  logic                  active_q;
  logic [1:0]            edge_cnt_q;
  logic                  old_rise;
  logic                  new_rise;
  logic                  act_rise;

  assign old_rise = active_q ? pin_rise[`PBCS_SYNC_VCO] : pin_rise[`PBCS_SYNC_XTAL];
  assign new_rise = active_q ? pin_rise[`PBCS_SYNC_XTAL] : pin_rise[`PBCS_SYNC_VCO];
  assign act_rise = old_rise;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q    <= pbcs_pkg::PBCS_RUN;
      active_q   <= 1'b0;
      edge_cnt_q <= 2'h0;
    end
    // Stop falls back to the crystal at once; the VCO may be halted and never give edges
    else if (stop_in)
    begin
      state_q    <= pbcs_pkg::PBCS_RUN;
      active_q   <= 1'b0;
      edge_cnt_q <= 2'h0;
    end
    else
    begin
      case (state_q)
        pbcs_pkg::PBCS_RUN:
          if (bcs_q != active_q)
          begin
            state_q    <= pbcs_pkg::PBCS_WAIT_OLD;
            edge_cnt_q <= 2'h0;
          end
        // A withdrawn request returns to the old source, which still owns the output
        pbcs_pkg::PBCS_WAIT_OLD:
          if (bcs_q == active_q)
            state_q <= pbcs_pkg::PBCS_RUN;
          else if (old_rise)
          begin
            if (edge_cnt_q == `PBCS_HOLD_EDGES - 2'h1)
            begin
              state_q    <= pbcs_pkg::PBCS_WAIT_NEW;
              edge_cnt_q <= 2'h0;
            end
            else
              edge_cnt_q <= edge_cnt_q + 2'h1;
          end
        pbcs_pkg::PBCS_WAIT_NEW:
          if (bcs_q == active_q)
            state_q <= pbcs_pkg::PBCS_RUN;
          else if (new_rise)
          begin
            if (edge_cnt_q == `PBCS_HOLD_EDGES - 2'h1)
            begin
              state_q    <= pbcs_pkg::PBCS_RUN;
              active_q   <= ~active_q;
              edge_cnt_q <= 2'h0;
            end
            else
              edge_cnt_q <= edge_cnt_q + 2'h1;
          end
        default:
          state_q <= pbcs_pkg::PBCS_RUN;
      endcase
    end
  end

  // Output toggles on each active-source rising edge, frozen during handover
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      base_clock_out <= 1'b0;
    else if (stop_in)
      base_clock_out <= 1'b0;
    else if (state_q == pbcs_pkg::PBCS_RUN && act_rise)
      base_clock_out <= ~base_clock_out;
  end

endmodule

// ==== logic/pbcs_defs.svh ====
// Register offsets, field positions, reset values and timing counts of the clock selector
`ifndef PBCS_DEFS_SVH
`define PBCS_DEFS_SVH

`define PBCS_ADDR_W          2
`define PBCS_OFF_CTRL        2'h0
`define PBCS_OFF_BWC         2'h1
`define PBCS_OFF_PROG        2'h2

`define PBCS_CTRL_IE         7
`define PBCS_CTRL_FLAG       6
`define PBCS_CTRL_PWR        5
`define PBCS_CTRL_BCS        4
`define PBCS_CTRL_LOW_ONES   4'hF

`define PBCS_BWC_AUTO        7
`define PBCS_BWC_LOCK        6
`define PBCS_BWC_TRK         5

`define PBCS_MUL_RESET       4'h6
`define PBCS_RNG_RESET       4'h6
`define PBCS_MUL_ONE         4'h1
`define PBCS_NIB_ZERO        4'h0

`define PBCS_HOLD_EDGES      2'h3

`define PBCS_SYNC_XTAL       0
`define PBCS_SYNC_VCO        1
`define PBCS_SYNC_LOCK       2
`define PBCS_SYNC_TRK        3
`define PBCS_SYNC_N          4

`endif

// ==== logic/pbcs_pkg.sv ====
// Types shared by the clock selector design
package pbcs_pkg;

  typedef enum logic [2:0]
  {
    PBCS_RUN      = 3'b001,
    PBCS_WAIT_OLD = 3'b010,
    PBCS_WAIT_NEW = 3'b100
  } pbcs_state_t;

endpackage

// ==== logic/pbcs_sync.sv ====
// Two-flop synchroniser with a rising-edge pulse decoded from the synced level and its delayed copy
module pbcs_sync
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic async_in,
  output logic      level_out,
  output logic      rise_out
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_out = sync_q;
  assign rise_out  = sync_q & ~prev_q;

endmodule

// ==== sim/pbcs_far.sv ====
// Far-side model: oscillator, VCO and lock detector pins
module pbcs_far
(
  input  wire logic lock_cmd,
  input  wire logic clk,
  output logic      crystal_clock,
  output logic      vco_clock,
  output logic      lock_detect_in,
  output logic      tracking_status_in,
  output logic      oscillator_enable_in
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  always @(posedge clk)
  begin
    n <= n + 1;
  end
  // Sources kept slow against clk so every edge is seen
  assign crystal_clock        = n[2];
  assign vco_clock            = (n % 6) < 3;
  assign lock_detect_in       = lock_cmd;
  assign tracking_status_in   = lock_cmd;
  assign oscillator_enable_in = 1'b1;
endmodule

// ==== sim/pbcs_top_assertions.sv ====
// Port-level assertions for the clock selector
`include "pbcs_defs.svh"
module pbcs_top_assertions
(
  input wire logic                    clk,
  input wire logic                    rst,
  input wire logic [`PBCS_ADDR_W-1:0] addr,
  input wire logic                    rd,
  input wire logic [7:0]              rdata,
  input wire logic                    oscillator_enable_in,
  input wire logic                    stop_in,
  input wire logic                    base_clock_out,
  input wire logic                    lock_irq_out,
  input wire logic                    loop_enable_out,
  input wire logic [3:0]              feedback_mult_out,
  input wire logic [3:0]              range_mult_out
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  a_mult_nonzero: assert property (feedback_mult_out != 4'h0)
    else $error("multiplier output is zero");
  a_range_zero_off: assert property (range_mult_out == 4'h0 |-> !loop_enable_out)
    else $error("loop enabled with zero range");
  a_div_spacing: assert property ($changed(base_clock_out) |=>
    ($stable(base_clock_out) || $past(stop_in))[*2])
    else $error("base clock toggled too fast");
  a_sel_needs_pwr: assert property (rd && addr == `PBCS_OFF_CTRL |=> !rdata[4] || rdata[5])
    else $error("select set with loop off");
  a_stop_base_low: assert property (stop_in ##1 stop_in |-> !base_clock_out)
    else $error("base clock active in stop");
  a_irq_stop_off: assert property (stop_in |=> !lock_irq_out)
    else $error("irq active in stop");
  a_ctrl_low_ones: assert property (rd && addr == `PBCS_OFF_CTRL |=> rdata[3:0] == 4'hF)
    else $error("control low bits not ones");
  a_loop_needs_osc: assert property (loop_enable_out |-> $past(oscillator_enable_in))
    else $error("loop enabled without oscillator enable");
endmodule
bind pbcs_top pbcs_top_assertions pbcs_top_assertions_inst (.clk(clk), .rst(rst), .addr(addr),
  .rd(rd), .rdata(rdata), .oscillator_enable_in(oscillator_enable_in), .stop_in(stop_in),
  .base_clock_out(base_clock_out), .lock_irq_out(lock_irq_out),
  .loop_enable_out(loop_enable_out), .feedback_mult_out(feedback_mult_out),
  .range_mult_out(range_mult_out));

// ==== sim/pbcs_top_tb.sv ====
// Self-checking bench for the clock selector
`include "pbcs_defs.svh"
module pbcs_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [1:0] C = `PBCS_OFF_CTRL;
  localparam logic [1:0] B = `PBCS_OFF_BWC;
  localparam logic [1:0] P = `PBCS_OFF_PROG;
  logic       clk      = 1'b0;
  logic       rst      = 1'b1;
  logic [1:0] addr     = 2'h0;
  logic [7:0] wdata    = 8'h00;
  logic       wr       = 1'b0;
  logic       rd       = 1'b0;
  logic       stop_in  = 1'b0;
  logic       lock_cmd = 1'b0;
  logic [7:0] rdata;
  logic       xc, vc, ld, ts, oe, bco, irq, le;
  logic       ce, tm;
  logic [3:0] fm, rm;
  int         err_total = 0;
  int         n_checks  = 0;
  pbcs_far pbcs_far_inst (.clk(clk), .lock_cmd(lock_cmd), .crystal_clock(xc), .vco_clock(vc),
    .lock_detect_in(ld), .tracking_status_in(ts), .oscillator_enable_in(oe));
  pbcs_top pbcs_top_inst (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .crystal_clock(xc), .vco_clock(vc), .lock_detect_in(ld),
    .tracking_status_in(ts), .oscillator_enable_in(oe), .stop_in(stop_in),
    .base_clock_out(bco), .lock_irq_out(irq), .crystal_enable_out(ce), .loop_enable_out(le),
    .tracking_mode_out(tm), .feedback_mult_out(fm), .range_mult_out(rm));
  initial
  begin
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [1:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [1:0] a, input logic [7:0] exp);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
    @(posedge clk);
  endtask
  // Counts clk cycles of one high phase of the base clock
  task automatic per(input logic [7:0] exp);
    logic [7:0] c;
    c = 8'h00;
    @(posedge bco);
    @(negedge clk);
    while (bco === 1'b1)
    begin
      c++;
      @(negedge clk);
    end
    chk(c, exp);
    @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rchk(C, 8'h2F);
    rchk(B, 8'h00);
    rchk(P, 8'h66);
    rchk(2'h3, 8'h00);
    chk({4'h0, fm}, 8'h06);
    chk({4'h0, rm}, 8'h06);
    chk({7'h00, ce}, 8'h01);
    chk({7'h00, tm}, 8'h00);
    per(8'h08);
    $display("t_reset done");
  endtask
  task automatic t_select();
    wreg(C, 8'h30);
    rchk(C, 8'h3F);
    per(8'h06);
    wreg(C, 8'h00);
    rchk(C, 8'h2F);
    per(8'h08);
    wreg(C, 8'h00);
    rchk(C, 8'h0F);
    chk({7'h00, le}, 8'h00);
    wreg(C, 8'h30);
    rchk(C, 8'h2F);
    wreg(C, 8'h30);
    rchk(C, 8'h3F);
    stop_in <= 1'b1;
    repeat (4) @(posedge clk);
    chk({7'h00, bco}, 8'h00);
    chk({7'h00, ce}, 8'h00);
    stop_in <= 1'b0;
    @(posedge clk);
    rchk(C, 8'h2F);
    $display("t_select done");
  endtask
  task automatic t_prog();
    wreg(C, 8'h00);
    wreg(P, 8'h00);
    rchk(P, 8'h00);
    chk({4'h0, fm}, 8'h01);
    chk({4'h0, rm}, 8'h00);
    wreg(B, 8'h00);
    chk({7'h00, tm}, 8'h00);
    wreg(C, 8'h20);
    wreg(C, 8'h30);
    rchk(C, 8'h2F);
    chk({7'h00, le}, 8'h00);
    $display("t_prog done");
  endtask
  task automatic t_lock();
    lock_cmd <= 1'b1;
    wreg(C, 8'hA0);
    rchk(C, 8'h2F);
    wreg(B, 8'h80);
    repeat (6) @(posedge clk);
    rchk(B, 8'hE0);
    chk({7'h00, tm}, 8'h01);
    wreg(C, 8'hA0);
    repeat (2) @(posedge clk);
    chk({7'h00, irq}, 8'h01);
    rchk(C, 8'hEF);
    repeat (2) @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    wreg(C, 8'hE0);
    rchk(C, 8'hAF);
    lock_cmd <= 1'b0;
    repeat (6) @(posedge clk);
    rchk(C, 8'hEF);
    // Read lands on the edge at which the synced lock toggle sets the flag
    lock_cmd <= 1'b1;
    repeat (2) @(posedge clk);
    rchk(C, 8'hAF);
    rchk(C, 8'hEF);
    wreg(B, 8'h00);
    rchk(C, 8'h2F);
    $display("t_lock done");
  endtask
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    #2000000;
    err_total++;
    report_and_stop();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_select();
    t_prog();
    t_lock();
    report_and_stop();
  end
endmodule
